// ---- rtl/cmcrc_pkg.sv ----
// Constants, types and CRC helpers shared by the configuration memory CRC checker.
package cmcrc_pkg;

	// ==========================================================
	// Configuration stream and memory geometry
	localparam int          FRAME_BYTES   = 16;
	localparam int          NUM_FRAMES    = 4;
	localparam int          CONFIGURATION_RAM_DEPTH    = FRAME_BYTES * NUM_FRAMES;
	localparam int          ADDR_W        = 6;
	localparam int          BYTE_CNT_W    = 5;
	localparam int          FRAME_CNT_W   = 2;
	localparam int          REF_BYTES     = 4;
	localparam logic [BYTE_CNT_W-1:0]  CNT_FRAME_DATA = 5'h10;
	localparam logic [FRAME_CNT_W-1:0] LAST_FRAME     = 2'h3;
	localparam logic [1:0]             LAST_REF_BYTE  = 2'h3;
	localparam logic [ADDR_W-1:0]      LAST_ADDR      = 6'h3f;

	// ==========================================================
	// CRC definitions
	localparam logic [15:0] FRAME_CRC_POLY = 16'h1021;
	localparam logic [15:0] FRAME_CRC_INIT = 16'hffff;
	localparam logic [31:0] CONFIGURATION_RAM_CRC_POLY  = 32'h04c11db7;
	localparam logic [31:0] CONFIGURATION_RAM_CRC_INIT  = 32'hffffffff;
	localparam logic [31:0] STORE_RESET    = 32'h00000000;
	localparam logic [31:0] SIG_CLEAN      = 32'h00000000;

	// ==========================================================
	// JTAG instruction and data registers
	localparam int          IR_W           = 10;
	localparam int          DR_W           = 32;
	localparam logic [9:0]  IR_LOAD_REF    = 10'h015;
	localparam logic [9:0]  IR_CAPTURE     = 10'h001;

	typedef enum logic [2:0] {
		CFG_LOAD,
		CFG_REF,
		CFG_USER,
		CFG_FAIL
	} cmcrc_cfg_t;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} cmcrc_tap_t;

	// Bytewise MSB-first CRC-16 step used for the per-frame check.
	function automatic logic [15:0] cmcrcFrameStep(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? ((c << 1) ^ FRAME_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// Bytewise MSB-first CRC-32 step with the IEEE 802 generator polynomial.
	function automatic logic [31:0] cmcrcCramStep(input logic [31:0] crc, input logic [7:0] b);
		logic [31:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[31] ^ b[i]) ? ((c << 1) ^ CONFIGURATION_RAM_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

// ---- rtl/cmcrc_mem_if.sv ----
// Interface between the checker control and the configuration RAM array.
`timescale 1ns/1ps
interface cmcrc_mem_if;
	import cmcrc_pkg::*;
	logic              wrEn;
	logic [ADDR_W-1:0] wrAddr;
	logic [7:0]        wrData;
	logic              flipEn;
	logic [ADDR_W-1:0] flipAddr;
	logic [2:0]        flipBit;
	logic [ADDR_W-1:0] rdAddr;
	logic [7:0]        rdData;

	modport ctrl (output wrEn, wrAddr, wrData, flipEn, flipAddr, flipBit, rdAddr, input rdData);
	modport mem  (input wrEn, wrAddr, wrData, flipEn, flipAddr, flipBit, rdAddr, output rdData);
endinterface

// ---- rtl/cmcrc_configuration_ram.sv ----
// Configuration RAM array with a write port, an upset port and a registered read port.
`timescale 1ns/1ps
module cmcrc_configuration_ram
	import cmcrc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rstSync_n,
	input  wire logic clkEn,
	cmcrc_mem_if.mem  bus
);

	logic [7:0] cells [CONFIGURATION_RAM_DEPTH];

	// ==========================================================
	// Storage
	// A load write wins over an upset on the same cycle; both never coincide in user mode.
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			if (bus.wrEn) begin
				cells[bus.wrAddr] <= bus.wrData;
			end else if (bus.flipEn) begin
				cells[bus.flipAddr][bus.flipBit] <= ~cells[bus.flipAddr][bus.flipBit];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			bus.rdData <= 8'h00;
		end else if (clkEn) begin
			bus.rdData <= cells[bus.rdAddr];
		end
	end

endmodule

// ---- rtl/cmcrc_checker.sv ----
// Configuration memory CRC checker: frame check at load, continuous user-mode scan, JTAG access.
`timescale 1ns/1ps

// Summary of operation
// - Check a CRC per incoming frame; stop loading at first mismatch.
// - At load end, store the stream's whole-image reference CRC in 32 bits.
// - In user mode, repeatedly CRC all configuration RAM and compare with reference.
// - User-mode checking runs until the reconfiguration input is pulled low.
// - Only configuration RAM cells feed the CRC; no block memory or I/O storage.
// - Use the IEEE 802 32-bit polynomial, one CRC over all configuration RAM.
// - Soft-error output is 0 for an all-zero signature, 1 otherwise.
// - JTAG instruction 0x015 puts the 32-bit store between TDI and TDO.
// - The store load instruction only takes effect in user mode.
// - User-mode checking is optional and, when enabled, runs on its own.
// - A frame CRC mismatch drives the configuration status output low.
module cmcrc_checker
	import cmcrc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	input  wire logic       reconfig_request_n,
	input  wire logic       cfgValid,
	input  wire logic [7:0] cfgByte,
	input  wire logic       checkEnable,
	input  wire logic       upsetValid,
	input  wire logic [5:0] upsetAddr,
	input  wire logic [2:0] upsetBit,
	input  wire logic       tck,
	input  wire logic       tms,
	input  wire logic       tdi,
	output logic            tdo,
	output logic            userMode,
	output logic            softError,
	output logic            config_status_n
);

	// ==========================================================
	// Reset release and pin synchronisers
	logic [1:0] rstPipe;
	logic       rstSync_n;
	logic [1:0] reconfigPipe;
	logic [1:0] tckPipe;
	logic [1:0] tmsPipe;
	logic [1:0] tdiPipe;
	logic       tckLast;
	logic       tckRise;
	logic       tckFall;
	logic       reconfigHeld;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe[1];

	// The TCK edge detector resets to the idle-high level, so no false edge follows reset.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			reconfigPipe <= 2'h3;
			tckPipe      <= 2'h3;
			tmsPipe      <= 2'h3;
			tdiPipe      <= 2'h3;
			tckLast      <= 1'b1;
		end else if (clkEn) begin
			reconfigPipe <= {reconfigPipe[0], reconfig_request_n};
			tckPipe      <= {tckPipe[0], tck};
			tmsPipe      <= {tmsPipe[0], tms};
			tdiPipe      <= {tdiPipe[0], tdi};
			tckLast      <= tckPipe[1];
		end
	end

	assign tckRise      = tckPipe[1] & ~tckLast;
	assign tckFall      = ~tckPipe[1] & tckLast;
	assign reconfigHeld = ~reconfigPipe[1];

	// ==========================================================
	// Configuration RAM
	cmcrc_mem_if memBus ();

	cmcrc_configuration_ram u_configuration_ram (
		.ref_clk   (ref_clk),
		.rstSync_n (rstSync_n),
		.clkEn     (clkEn),
		.bus       (memBus.mem)
	);

	// ==========================================================
	// Configuration load
	cmcrc_cfg_t            cfgState;
	logic [BYTE_CNT_W-1:0]  byteCnt;
	logic [FRAME_CNT_W-1:0] frameCnt;
	logic [15:0]            frameCrc;
	logic [7:0]             crcHigh;
	logic [1:0]             refCnt;
	logic [23:0]            refShift;
	logic                   loadData;
	logic                   refDone;
	logic [31:0]            refWord;

	assign loadData = (cfgState == CFG_LOAD) && cfgValid && (byteCnt < CNT_FRAME_DATA);
	assign refDone  = (cfgState == CFG_REF) && cfgValid && (refCnt == LAST_REF_BYTE);
	assign refWord  = {refShift, cfgByte};

	assign memBus.wrEn     = loadData;
	assign memBus.wrAddr   = {frameCnt, byteCnt[3:0]};
	assign memBus.wrData   = cfgByte;
	assign memBus.flipEn   = upsetValid;
	assign memBus.flipAddr = upsetAddr;
	assign memBus.flipBit  = upsetBit;

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cfgState <= CFG_LOAD;
			byteCnt  <= '0;
			frameCnt <= '0;
			frameCrc <= FRAME_CRC_INIT;
			crcHigh  <= 8'h00;
			refCnt   <= 2'h0;
			refShift <= 24'h000000;
		end else if (clkEn) begin
			if (reconfigHeld) begin
				cfgState <= CFG_LOAD;
				byteCnt  <= '0;
				frameCnt <= '0;
				frameCrc <= FRAME_CRC_INIT;
				refCnt   <= 2'h0;
			end else if (cfgValid) begin
				case (cfgState)
					CFG_LOAD: begin
						if (byteCnt < CNT_FRAME_DATA) begin
							frameCrc <= cmcrcFrameStep(frameCrc, cfgByte);
							byteCnt  <= byteCnt + 5'h01;
						end else if (byteCnt == CNT_FRAME_DATA) begin
							crcHigh <= cfgByte;
							byteCnt <= byteCnt + 5'h01;
						end else if ({crcHigh, cfgByte} != frameCrc) begin
							cfgState <= CFG_FAIL;
						end else begin
							frameCrc <= FRAME_CRC_INIT;
							byteCnt  <= '0;
							if (frameCnt == LAST_FRAME) begin
								cfgState <= CFG_REF;
							end else begin
								frameCnt <= frameCnt + 2'h1;
							end
						end
					end
					CFG_REF: begin
						refShift <= refWord[23:0];
						refCnt   <= refCnt + 2'h1;
						if (refCnt == LAST_REF_BYTE) begin
							cfgState <= CFG_USER;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// A held reconfiguration request also pulls the status line low, as on a real part.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			config_status_n <= 1'b1;
			userMode        <= 1'b0;
		end else if (clkEn) begin
			config_status_n <= !(reconfigHeld || cfgState == CFG_FAIL);
			userMode        <= (cfgState == CFG_USER) && !reconfigHeld;
		end
	end

	// ==========================================================
	// JTAG access to the reference store
	cmcrc_tap_t       tapState;
	logic [IR_W-1:0]  irShift;
	logic [IR_W-1:0]  irActive;
	logic [DR_W-1:0]  drShift;
	logic             bypassBit;
	logic             selLoadRef;
	logic [31:0]      referenceCrcStore;

	assign selLoadRef = (irActive == IR_LOAD_REF);

	function automatic cmcrc_tap_t tapNext(input cmcrc_tap_t s, input logic m);
		case (s)
			TAP_RESET:    tapNext = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     tapNext = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tapNext = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tapNext = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   tapNext = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   tapNext = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tapNext = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tapNext = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			default:      tapNext = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			tapState  <= TAP_RESET;
			irShift   <= '0;
			irActive  <= '0;
			drShift   <= '0;
			bypassBit <= 1'b0;
		end else if (clkEn && tckRise) begin
			tapState <= tapNext(tapState, tmsPipe[1]);
			case (tapState)
				TAP_RESET:    irActive <= '0;
				TAP_CAP_IR:   irShift  <= IR_CAPTURE;
				TAP_SHIFT_IR: irShift  <= {tdiPipe[1], irShift[IR_W-1:1]};
				TAP_UPD_IR:   irActive <= irShift;
				TAP_CAP_DR: begin
					drShift   <= referenceCrcStore;
					bypassBit <= 1'b0;
				end
				TAP_SHIFT_DR: begin
					if (selLoadRef) begin
						drShift <= {tdiPipe[1], drShift[DR_W-1:1]};
					end else begin
						bypassBit <= tdiPipe[1];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// TDO changes on the falling TCK edge so the host samples it stable on the rise.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			tdo <= 1'b0;
		end else if (clkEn && tckFall) begin
			if (tapState == TAP_SHIFT_IR) begin
				tdo <= irShift[0];
			end else if (tapState == TAP_SHIFT_DR) begin
				tdo <= selLoadRef ? drShift[0] : bypassBit;
			end
		end
	end

	// ==========================================================
	// Reference store
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			referenceCrcStore <= STORE_RESET;
		end else if (clkEn) begin
			if (refDone) begin
				referenceCrcStore <= refWord;
			end else if (tckRise && tapState == TAP_UPD_DR && selLoadRef && userMode) begin
				referenceCrcStore <= drShift;
			end
		end
	end

	// ==========================================================
	// User-mode scan
	// Only the configuration RAM array is read; no other storage enters the CRC.
	logic [ADDR_W-1:0] scanAddr;
	logic              rdValid;
	logic              rdLast;
	logic [31:0]       cramCrc;
	logic [31:0]       crcNext;
	logic [31:0]       signature;
	logic              scanOn;

	assign scanOn        = userMode && checkEnable && !reconfigHeld;
	assign memBus.rdAddr = scanAddr;
	assign crcNext       = cmcrcCramStep(cramCrc, memBus.rdData);

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			scanAddr  <= '0;
			rdValid   <= 1'b0;
			rdLast    <= 1'b0;
			cramCrc   <= CONFIGURATION_RAM_CRC_INIT;
			signature <= SIG_CLEAN;
			softError <= 1'b0;
		end else if (clkEn) begin
			if (!scanOn) begin
				scanAddr  <= '0;
				rdValid   <= 1'b0;
				rdLast    <= 1'b0;
				cramCrc   <= CONFIGURATION_RAM_CRC_INIT;
				signature <= SIG_CLEAN;
				softError <= 1'b0;
			end else begin
				scanAddr <= scanAddr + 6'h01;
				rdValid  <= 1'b1;
				rdLast   <= (scanAddr == LAST_ADDR);
				if (rdValid) begin
					if (rdLast) begin
						signature <= crcNext ^ referenceCrcStore;
						softError <= ((crcNext ^ referenceCrcStore) != SIG_CLEAN);
						cramCrc   <= CONFIGURATION_RAM_CRC_INIT;
					end else begin
						cramCrc <= crcNext;
					end
				end
			end
		end
	end

endmodule

// ---- tb/cmcrc_sva_checker.sv ----
// Port-level assertions for the configuration memory CRC checker.
`timescale 1ns/1ps
module cmcrc_sva_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reconfig_request_n,
	input wire logic cfgValid,
	input wire logic checkEnable,
	input wire logic tck,
	input wire logic tdo,
	input wire logic userMode,
	input wire logic softError,
	input wire logic config_status_n
);
	// ==========================================================
	// Helper counters
	logic [3:0] sinceCut;
	logic [3:0] tckLow;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sinceCut <= 4'h0;
		end else if (!reconfig_request_n) begin
			sinceCut <= 4'h0;
		end else if (sinceCut != 4'hf) begin
			sinceCut <= sinceCut + 4'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tckLow <= 4'h0;
		end else if (tck) begin
			tckLow <= 4'h0;
		end else if (tckLow != 4'hf) begin
			tckLow <= tckLow + 4'h1;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_cutHeld;
		!reconfig_request_n [*4];
	endsequence
	sequence s_refTaken;
		$past(cfgValid, 2);
	endsequence

	property p_user_rise;   $rose(userMode) |-> s_refTaken; endproperty
	property p_user_drop;   s_cutHeld |-> !userMode; endproperty
	property p_fail_cause;  $fell(config_status_n) |-> s_refTaken or sinceCut <= 4'h4; endproperty
	property p_fail_hold;   $rose(config_status_n) |-> sinceCut <= 4'h6; endproperty
	property p_no_user_fail;
		!config_status_n && $past(!config_status_n) |-> !userMode;
	endproperty
	property p_scan_off;    !checkEnable [*3] |-> !softError; endproperty
	property p_scan_user;   !userMode [*3] |-> !softError; endproperty
	property p_soft_steady;
		$changed(softError) && checkEnable |=>
			($stable(softError) || !userMode || !checkEnable) [*8];
	endproperty
	property p_tdo_fall;    $changed(tdo) |-> tckLow != 4'h0 && tckLow <= 4'h6; endproperty

	a_user_rise:    assert property (p_user_rise) else $error("user mode without reference");
	a_user_drop:    assert property (p_user_drop) else $error("user mode kept in reconfig");
	a_fail_cause:   assert property (p_fail_cause) else $error("status fell without cause");
	a_fail_hold:    assert property (p_fail_hold) else $error("status left fail early");
	a_no_user_fail: assert property (p_no_user_fail) else $error("user mode while failed");
	a_scan_off:     assert property (p_scan_off) else $error("soft error with scan off");
	a_scan_user:    assert property (p_scan_user) else $error("soft error outside user");
	a_soft_steady:  assert property (p_soft_steady) else $error("soft error mid pass");
	a_tdo_fall:     assert property (p_tdo_fall) else $error("tdo moved off tck fall");
endmodule

bind cmcrc_checker cmcrc_sva_checker u_sva (
	.ref_clk(ref_clk), .rst_n(rst_n), .reconfig_request_n(reconfig_request_n),
	.cfgValid(cfgValid), .checkEnable(checkEnable), .tck(tck), .tdo(tdo),
	.userMode(userMode), .softError(softError), .config_status_n(config_status_n));

// ---- tb/cmcrc_jtag_host.sv ----
// Model of the JTAG test host and of the system driving the reconfiguration request.
`timescale 1ns/1ps
module cmcrc_jtag_host
	import cmcrc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      reconfig_request_n
);
	// TCK idles high, the level the design's edge detector assumes after reset.
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
		reconfig_request_n = 1'b1;
	end

	// Each half period lasts six ref_clk cycles so the synchronisers see every edge.
	task automatic step(input logic m, input logic d, output logic q);
		@(negedge ref_clk);
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (6) @(negedge ref_clk);
		q = tdo;
		tck = 1'b1;
		repeat (5) @(negedge ref_clk);
	endtask

	// Outside shifting tdi toggles, so no stale level is mistaken for data.
	task automatic walk(input logic [7:0] pat, input int n);
		logic q;
		for (int i = 0; i < n; i++) step(pat[i], ~tdi, q);
	endtask

	task automatic shift(input int n, input logic [31:0] w, output logic [31:0] r);
		logic q;
		r = 32'h0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, w[i], q);
			r[i] = q;
		end
	endtask

	task automatic access(input logic [31:0] w, output logic [31:0] r);
		logic [31:0] ir;
		walk(8'h1f, 6);
		walk(8'h03, 4);
		shift(IR_W, {22'h0, IR_LOAD_REF}, ir);
		walk(8'h05, 5);
		shift(DR_W, w, r);
		walk(8'h01, 2);
	endtask

	task automatic pulseReconfig();
		reconfig_request_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		reconfig_request_n = 1'b1;
	endtask
endmodule

// ---- tb/cmcrc_checker_tb.sv ----
// Self-checking testbench for the configuration memory CRC checker.
`timescale 1ns/1ps
module cmcrc_checker_tb;
	import cmcrc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n, cfgValid, checkEnable, upsetValid, clkEn;
	logic [7:0]  cfgByte;
	logic [5:0]  upsetAddr;
	logic [2:0]  upsetBit;
	logic        tck, tms, tdi, tdo, reconfig_request_n;
	logic        userMode, softError, config_status_n;
	logic [7:0]  img [CONFIGURATION_RAM_DEPTH];
	logic [31:0] goodRef, rdBack, rdAgain;
	int          fail_count = 0;
	int          n_compared = 0;

	always #20 ref_clk = ~ref_clk;

	cmcrc_checker u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.reconfig_request_n(reconfig_request_n), .cfgValid(cfgValid), .cfgByte(cfgByte),
		.checkEnable(checkEnable), .upsetValid(upsetValid), .upsetAddr(upsetAddr),
		.upsetBit(upsetBit), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.userMode(userMode), .softError(softError), .config_status_n(config_status_n));
	cmcrc_jtag_host u_host (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
		.reconfig_request_n(reconfig_request_n));

	// ==========================================================
	// Checking helpers
	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b,
		input logic [31:0] poly, input int top);
		for (int i = 7; i >= 0; i--) c = (c[top] ^ b[i]) ? ((c << 1) ^ poly) : (c << 1);
		return c;
	endfunction

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic waitSoft(input logic v);
		for (int n = 0; n < 300 && softError !== v; n++) @(negedge ref_clk);
		chk(softError, v, "soft error");
	endtask

	task automatic sendByte(input logic [7:0] b);
		cfgValid = 1'b1;
		cfgByte = b;
		@(negedge ref_clk);
	endtask

	// A negative frame index sends a clean image with its reference.
	task automatic loadImage(input int bad);
		logic [31:0] ref32;
		logic [31:0] fc;
		ref32 = CONFIGURATION_RAM_CRC_INIT;
		for (int f = 0; f < NUM_FRAMES; f++) begin
			fc = {16'h0, FRAME_CRC_INIT};
			for (int i = 0; i < FRAME_BYTES; i++) begin
				sendByte(img[f * FRAME_BYTES + i]);
				fc = crcByte(fc, img[f * FRAME_BYTES + i], {16'h0, FRAME_CRC_POLY}, 15);
				ref32 = crcByte(ref32, img[f * FRAME_BYTES + i], CONFIGURATION_RAM_CRC_POLY, 31);
			end
			sendByte(fc[15:8]);
			sendByte(fc[7:0] ^ {7'h0, f == bad});
			if (f == bad) break;
		end
		if (bad < 0) begin
			goodRef = ref32;
			for (int k = 3; k >= 0; k--) sendByte(ref32[k * 8 +: 8]);
		end
		cfgValid = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(userMode, bad < 0, "user mode");
		chk(config_status_n, bad < 0, "status");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		cfgValid = 1'b0;
		cfgByte = 8'h00;
		checkEnable = 1'b0;
		upsetValid = 1'b0;
		upsetAddr = 6'h2a;
		upsetBit = 3'h5;
		for (int k = 0; k < CONFIGURATION_RAM_DEPTH; k++) img[k] = 8'(k * 37 + 11);
		repeat (3) @(negedge ref_clk);
		chk({userMode, softError, config_status_n}, 32'h1, "reset outputs");
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		loadImage(-1);
		checkEnable = 1'b1;
		repeat (200) @(negedge ref_clk);
		chk(softError, 1'b0, "clean scan");
		u_host.access(goodRef, rdBack);
		chk(rdBack, goodRef, "read reference");
		u_host.access(goodRef ^ 32'h00000100, rdBack);
		waitSoft(1'b1);
		u_host.access(goodRef, rdBack);
		chk(rdBack, goodRef ^ 32'h00000100, "injected reference");
		waitSoft(1'b0);
		// An upset offered while the clock enable is low must not reach the array.
		clkEn = 1'b0;
		upsetValid = 1'b1;
		repeat (2) @(negedge ref_clk);
		upsetValid = 1'b0;
		clkEn = 1'b1;
		repeat (150) @(negedge ref_clk);
		chk(softError, 1'b0, "upset while frozen");
		upsetValid = 1'b1;
		@(negedge ref_clk);
		upsetValid = 1'b0;
		waitSoft(1'b1);
		checkEnable = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(softError, 1'b0, "scan disabled");
		checkEnable = 1'b1;
		waitSoft(1'b1);
		u_host.pulseReconfig();
		chk(userMode, 1'b0, "after reconfig");
		repeat (3) @(negedge ref_clk);
		loadImage(1);
		u_host.access(32'h5aa5c33c, rdBack);
		chk(rdBack, goodRef, "reference after reconfig");
		u_host.access(32'h00000000, rdAgain);
		chk(rdAgain, goodRef, "write outside user mode");
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		chk({userMode, softError, config_status_n}, 32'h1, "power cycle");
		stop_test();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		fail_count++;
		stop_test();
	end
endmodule
